// ===== shared/muoa_pkg.sv
/*
 * Constants, enumerations and carrier structs shared by the multi user
 * owner arbiter and its ownership table.
 * Assumes a single 10 MHz clock and a synchronous active low reset.
 */
package muoa_pkg;

    // ********************************************************************
    // Clock and timing
    // ********************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int HB_PERIOD_MS = 2000;
    localparam int HB_ON_MS = 100;
    localparam int OL_FLASH_HZ = 4;
    localparam int OL_PERIOD_MS = MS_PER_S / OL_FLASH_HZ;
    localparam int OL_ON_MS = OL_PERIOD_MS / 2;
    localparam int PRE_W = 16;
    localparam int MS_W = 11;

    // ********************************************************************
    // Sizes
    // ********************************************************************
    localparam int NUM_USERS = 3;
    localparam int UID_W = 2;
    localparam int ADDR_W = 14;
    localparam int ENG_SLOTS = 8;
    localparam int ACC_SLOTS = 8;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LINKS = 8'h08;
    localparam int CTRL_ENG_LOCK_BIT = 0;
    localparam int CTRL_ACC_LOCK_BIT = 1;
    localparam int CTRL_OL_CLEAR_BIT = 2;
    localparam logic [1:0] LOCKS_RESET = 2'h3;
    localparam logic [2:0] LINKS_LARGE = 3'h6;
    localparam logic [2:0] LINKS_SMALL = 3'h7;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_OPER = 2'b01,
        MODE_SERVICE = 2'b10
    } muoa_mode_e;

    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_GO_OPER = 3'b001,
        CMD_GO_SERVICE = 3'b010,
        CMD_GO_IDLE = 3'b011,
        CMD_SEL_ENGINE = 3'b100,
        CMD_ENGINE = 3'b101,
        CMD_ACCESSORY = 3'b110,
        CMD_SERVICE_OP = 3'b111
    } muoa_cmd_e;

    typedef struct packed {
        logic valid;
        muoa_cmd_e cmd;
        logic [ADDR_W-1:0] addr;
    } muoa_req_s;

    typedef struct packed {
        logic done;
        logic granted;
        logic locked;
    } muoa_rsp_s;

endpackage

// ===== verilog/muoa_own_table.sv
/*
 * Ownership table: maps an address to the user that claimed it.
 * Assumes claim is asserted only when the lookup address has no owner.
 */
`timescale 1ns/100ps
module muoa_own_table #(
    parameter int SLOTS = muoa_pkg::ENG_SLOTS
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire logic [muoa_pkg::ADDR_W-1:0] addr_in,
    input wire logic claim_in,
    input wire logic [muoa_pkg::UID_W-1:0] uid_in,
    output logic hit_out,
    output logic [muoa_pkg::UID_W-1:0] hit_uid_out,
    output logic full_out
);

    logic [SLOTS-1:0] used_reg, used_next;
    logic [muoa_pkg::ADDR_W-1:0] addr_reg [SLOTS];
    logic [muoa_pkg::ADDR_W-1:0] addr_next [SLOTS];
    logic [muoa_pkg::UID_W-1:0] uid_reg [SLOTS];
    logic [muoa_pkg::UID_W-1:0] uid_next [SLOTS];
    logic free_found;

    // ********************************************************************
    // Lookup and claim
    // ********************************************************************
    always_comb begin
        used_next = used_reg;
        addr_next = addr_reg;
        uid_next = uid_reg;
        hit_out = 1'b0;
        hit_uid_out = '0;
        free_found = 1'b0;
        for (int i = 0; i < SLOTS; i++) begin
            if (used_reg[i] && addr_reg[i] == addr_in) begin
                hit_out = 1'b1;
                hit_uid_out = uid_reg[i];
            end
        end
        full_out = &used_reg;
        for (int i = 0; i < SLOTS; i++) begin
            if (claim_in && !hit_out && !used_reg[i] && !free_found) begin
                used_next[i] = 1'b1;
                addr_next[i] = addr_in;
                uid_next[i] = uid_in;
                free_found = 1'b1;
            end
        end
        if (clear_in) begin
            used_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            used_reg <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                addr_reg[i] <= '0;
                uid_reg[i] <= '0;
            end
        end else begin
            used_reg <= used_next;
            addr_reg <= addr_next;
            uid_reg <= uid_next;
        end
    end

endmodule

// ===== verilog/muoa_arbiter.sv
/*
 * Multi user owner arbiter: state owner, engine and accessory ownership,
 * locking options, status LED and track bridge enable.
 * Assumes decoded user requests on the same clock, held until done, and
 * a software register port with read data one cycle after the strobe.
 */
`timescale 1ns/100ps
// How it works
// - Heartbeat LED blinks once per two seconds in idle or operational mode.
// - Service mode LED dark except while acknowledge sampling input is high.
// - Overload disables track bridge, LED flashes four times per second.
// - Up to three users served, one request per cycle, fixed priority.
// - Small board strap makes all three user channels wireless.
// - Two users never control the same engine address together while the engine lock is on.
// - Service operations accepted only from the state owner in service mode.
// - First mode requester becomes owner; only owner changes mode later.
// - Engine command after selection claims that address until idle.
// - Command to engine owned by another user refused and flagged locked while the engine lock is on.
// - Engine and accessory locks each switch on or off independently.
// - Link transmit goes to module receive, module transmit to our receive.
module muoa_arbiter #(
    parameter int CYC_PER_MS = muoa_pkg::CYC_PER_MS,
    parameter int NUM_USERS = muoa_pkg::NUM_USERS
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire muoa_pkg::muoa_req_s [NUM_USERS-1:0] req_in,
    output muoa_pkg::muoa_rsp_s [NUM_USERS-1:0] rsp_out,
    input wire logic overload_in,
    input wire logic ack_sample_in,
    input wire logic small_board_in,
    input wire logic [NUM_USERS-1:0] link_tx_in,
    output logic [NUM_USERS-1:0] link_tx_pin_out,
    input wire logic [NUM_USERS-1:0] link_rx_pin_in,
    output logic [NUM_USERS-1:0] link_rx_out,
    output logic led_out,
    output logic bridge_en_out,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out
);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // ********************************************************************
    // State
    // ********************************************************************
    muoa_pkg::muoa_mode_e mode_reg, mode_next;
    logic owner_vld_reg, owner_vld_next;
    logic [muoa_pkg::UID_W-1:0] owner_reg, owner_next;
    logic [muoa_pkg::ADDR_W-1:0] sel_addr_reg [NUM_USERS];
    logic [muoa_pkg::ADDR_W-1:0] sel_addr_next [NUM_USERS];
    logic [NUM_USERS-1:0] sel_has_reg, sel_has_next;
    muoa_pkg::muoa_rsp_s [NUM_USERS-1:0] rsp_reg, rsp_next;
    logic [1:0] locks_reg, locks_next;
    logic overload_reg, overload_next;
    logic bridge_reg, bridge_next;
    logic led_reg, led_next;
    logic [muoa_pkg::PRE_W-1:0] pre_reg, pre_next;
    logic [muoa_pkg::MS_W-1:0] hb_ms_reg, hb_ms_next;
    logic [muoa_pkg::MS_W-1:0] ol_ms_reg, ol_ms_next;
    logic [31:0] rdata_reg, rdata_next;
    logic strap_meta_reg, strap_sync_reg;
    logic strap_done_reg, strap_done_next;
    logic [NUM_USERS-1:0] links_reg, links_next;
    logic [NUM_USERS-1:0] tx_reg, rx_meta_reg, rx_sync_reg;

    logic sel_vld, granted, locked, tbl_clear;
    logic [muoa_pkg::UID_W-1:0] sel_uid;
    muoa_pkg::muoa_req_s sel_req;
    logic eng_hit, eng_full, eng_claim, acc_hit, acc_full, acc_claim;
    logic [muoa_pkg::UID_W-1:0] eng_hit_uid, acc_hit_uid;
    logic [muoa_pkg::ADDR_W-1:0] eng_addr;
    logic eng_other, acc_other, ol_clear, ms_tick;

    // ********************************************************************
    // Request selection
    // ********************************************************************
    always_comb begin
        sel_vld = 1'b0;
        sel_uid = '0;
        for (int u = NUM_USERS - 1; u >= 0; u--) begin
            if (req_in[u].valid && !rsp_reg[u].done) begin
                sel_vld = 1'b1;
                sel_uid = muoa_pkg::UID_W'(u);
            end
        end
        sel_req = req_in[sel_uid];
        eng_addr = sel_addr_reg[sel_uid];
    end

    muoa_own_table #(
        .SLOTS(muoa_pkg::ENG_SLOTS)
    ) u_eng_table (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(tbl_clear),
        .addr_in(eng_addr),
        .claim_in(eng_claim),
        .uid_in(sel_uid),
        .hit_out(eng_hit),
        .hit_uid_out(eng_hit_uid),
        .full_out(eng_full)
    );

    muoa_own_table #(
        .SLOTS(muoa_pkg::ACC_SLOTS)
    ) u_acc_table (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(tbl_clear),
        .addr_in(sel_req.addr),
        .claim_in(acc_claim),
        .uid_in(sel_uid),
        .hit_out(acc_hit),
        .hit_uid_out(acc_hit_uid),
        .full_out(acc_full)
    );

    // ********************************************************************
    // Arbitration
    // ********************************************************************
    always_comb begin
        mode_next = mode_reg;
        owner_vld_next = owner_vld_reg;
        owner_next = owner_reg;
        sel_addr_next = sel_addr_reg;
        sel_has_next = sel_has_reg;
        rsp_next = '0;
        granted = 1'b0;
        locked = 1'b0;
        tbl_clear = 1'b0;
        eng_claim = 1'b0;
        acc_claim = 1'b0;
        eng_other = eng_hit && eng_hit_uid != sel_uid;
        acc_other = acc_hit && acc_hit_uid != sel_uid;
        if (sel_vld) begin
            unique case (sel_req.cmd)
                muoa_pkg::CMD_NONE: begin
                    granted = 1'b0;
                end
                muoa_pkg::CMD_GO_OPER, muoa_pkg::CMD_GO_SERVICE: begin
                    if (!owner_vld_reg || owner_reg == sel_uid) begin
                        granted = 1'b1;
                        owner_vld_next = 1'b1;
                        owner_next = sel_uid;
                        mode_next = (sel_req.cmd == muoa_pkg::CMD_GO_OPER) ?
                            muoa_pkg::MODE_OPER : muoa_pkg::MODE_SERVICE;
                    end
                end
                muoa_pkg::CMD_GO_IDLE: begin
                    if (!owner_vld_reg || owner_reg == sel_uid) begin
                        granted = 1'b1;
                        mode_next = muoa_pkg::MODE_IDLE;
                        owner_vld_next = 1'b0;
                        owner_next = '0;
                        tbl_clear = 1'b1;
                    end
                end
                muoa_pkg::CMD_SEL_ENGINE: begin
                    granted = 1'b1;
                    sel_addr_next[sel_uid] = sel_req.addr;
                    sel_has_next[sel_uid] = 1'b1;
                end
                muoa_pkg::CMD_ENGINE: begin
                    if (mode_reg == muoa_pkg::MODE_OPER &&
                        sel_has_reg[sel_uid]) begin
                        if (locks_reg[muoa_pkg::CTRL_ENG_LOCK_BIT] &&
                            eng_other) begin
                            locked = 1'b1;
                        end else if (eng_hit || !eng_full) begin
                            granted = 1'b1;
                            eng_claim = !eng_hit;
                        end
                    end
                end
                muoa_pkg::CMD_ACCESSORY: begin
                    if (mode_reg == muoa_pkg::MODE_OPER) begin
                        if (locks_reg[muoa_pkg::CTRL_ACC_LOCK_BIT] &&
                            acc_other) begin
                            locked = 1'b1;
                        end else if (acc_hit || !acc_full) begin
                            granted = 1'b1;
                            acc_claim = !acc_hit;
                        end
                    end
                end
                muoa_pkg::CMD_SERVICE_OP: begin
                    granted = mode_reg == muoa_pkg::MODE_SERVICE &&
                        owner_vld_reg && owner_reg == sel_uid;
                end
            endcase
            rsp_next[sel_uid].done = 1'b1;
            rsp_next[sel_uid].granted = granted;
            rsp_next[sel_uid].locked = locked;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            mode_reg <= muoa_pkg::MODE_IDLE;
            owner_vld_reg <= 1'b0;
            owner_reg <= '0;
            sel_has_reg <= '0;
            rsp_reg <= '0;
            for (int u = 0; u < NUM_USERS; u++) begin
                sel_addr_reg[u] <= '0;
            end
        end else begin
            mode_reg <= mode_next;
            owner_vld_reg <= owner_vld_next;
            owner_reg <= owner_next;
            sel_has_reg <= sel_has_next;
            rsp_reg <= rsp_next;
            sel_addr_reg <= sel_addr_next;
        end
    end

    // ********************************************************************
    // Overload, timing and LED
    // ********************************************************************
    always_comb begin
        ol_clear = reg_wr_in && reg_addr_in == muoa_pkg::REG_CTRL &&
            reg_wdata_in[muoa_pkg::CTRL_OL_CLEAR_BIT];
        overload_next = overload_in || (overload_reg && !ol_clear);
        bridge_next = !overload_reg;
        ms_tick = pre_reg == muoa_pkg::PRE_W'(CYC_PER_MS - 1);
        pre_next = ms_tick ? '0 : pre_reg + 1'b1;
        hb_ms_next = hb_ms_reg;
        ol_ms_next = ol_ms_reg;
        if (ms_tick) begin
            hb_ms_next = (hb_ms_reg ==
                muoa_pkg::MS_W'(muoa_pkg::HB_PERIOD_MS - 1)) ?
                '0 : hb_ms_reg + 1'b1;
            ol_ms_next = (ol_ms_reg ==
                muoa_pkg::MS_W'(muoa_pkg::OL_PERIOD_MS - 1)) ?
                '0 : ol_ms_reg + 1'b1;
        end
        if (overload_reg) begin
            led_next = ol_ms_reg <
                muoa_pkg::MS_W'(muoa_pkg::OL_ON_MS);
        end else if (mode_reg == muoa_pkg::MODE_SERVICE) begin
            led_next = ack_sample_in;
        end else begin
            led_next = hb_ms_reg <
                muoa_pkg::MS_W'(muoa_pkg::HB_ON_MS);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            overload_reg <= 1'b0;
            bridge_reg <= 1'b0;
            led_reg <= 1'b0;
            pre_reg <= '0;
            hb_ms_reg <= '0;
            ol_ms_reg <= '0;
        end else begin
            overload_reg <= overload_next;
            bridge_reg <= bridge_next;
            led_reg <= led_next;
            pre_reg <= pre_next;
            hb_ms_reg <= hb_ms_next;
            ol_ms_reg <= ol_ms_next;
        end
    end

    // ********************************************************************
    // Strap, links and pins
    // ********************************************************************
    always_comb begin
        strap_done_next = 1'b1;
        links_next = links_reg;
        if (!strap_done_reg) begin
            links_next = strap_sync_reg ? muoa_pkg::LINKS_SMALL :
                muoa_pkg::LINKS_LARGE;
        end
    end

    always_ff @(posedge clk_in) begin
        strap_meta_reg <= small_board_in;
        strap_sync_reg <= strap_meta_reg;
        rx_meta_reg <= link_rx_pin_in;
        rx_sync_reg <= rx_meta_reg;
        if (!nrst_in) begin
            strap_done_reg <= 1'b0;
            links_reg <= muoa_pkg::LINKS_LARGE;
            tx_reg <= '1;
        end else begin
            strap_done_reg <= strap_done_next;
            links_reg <= links_next;
            tx_reg <= link_tx_in;
        end
    end

    // ********************************************************************
    // Register port
    // ********************************************************************
    always_comb begin
        locks_next = locks_reg;
        rdata_next = '0;
        if (reg_wr_in && reg_addr_in == muoa_pkg::REG_CTRL) begin
            locks_next = reg_wdata_in[1:0];
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                muoa_pkg::REG_CTRL: rdata_next = {30'h0, locks_reg};
                muoa_pkg::REG_STATUS: rdata_next = {26'h0, strap_sync_reg,
                    overload_reg, owner_reg, owner_vld_reg, mode_reg[1]} |
                    {31'h0, mode_reg[0]} << 6;
                muoa_pkg::REG_LINKS: rdata_next = {29'h0, links_reg};
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            locks_reg <= muoa_pkg::LOCKS_RESET;
            rdata_reg <= '0;
        end else begin
            locks_reg <= locks_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rsp_out = rsp_reg;
    assign led_out = led_reg;
    assign bridge_en_out = bridge_reg;
    assign link_tx_pin_out = tx_reg;
    assign link_rx_out = rx_sync_reg;
    assign reg_rdata_out = rdata_reg;

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_heartbeat_led_off: assert property (
        (!overload_reg && mode_reg != muoa_pkg::MODE_SERVICE &&
        hb_ms_reg >= muoa_pkg::MS_W'(muoa_pkg::HB_ON_MS)) |=> !led_out)
        else $error("heartbeat led lit outside its on time");
    a_service_led_dark: assert property (
        (mode_reg == muoa_pkg::MODE_SERVICE && !overload_reg &&
        !ack_sample_in) |=> !led_out)
        else $error("service mode led lit without ack sampling");
    a_overload_bridge_off: assert property (
        overload_in |-> ##2 !bridge_en_out)
        else $error("bridge still enabled after overload");
    a_overload_led_flash: assert property (
        (overload_reg && ol_ms_reg == '0) |=> led_out)
        else $error("overload flash missing");
    a_one_done_pulse: assert property (
        $onehot0({rsp_reg[2].done, rsp_reg[1].done, rsp_reg[0].done}))
        else $error("more than one user answered in a cycle");
    a_user0_served: assert property (
        (req_in[0].valid && !rsp_reg[0].done) |=> rsp_reg[0].done)
        else $error("top priority user not answered next cycle");
    a_links_fixed: assert property (
        (strap_done_reg && $past(strap_done_reg)) |-> $stable(links_reg))
        else $error("link kinds changed after strap capture");
    a_engine_locked: assert property (
        (sel_vld && sel_req.cmd == muoa_pkg::CMD_ENGINE &&
        mode_reg == muoa_pkg::MODE_OPER && sel_has_reg[sel_uid] &&
        locks_reg[0] && eng_other) |=>
        rsp_reg[$past(sel_uid)].locked && !rsp_reg[$past(sel_uid)].granted)
        else $error("engine owned by another user not refused");
    a_service_refused: assert property (
        (sel_vld && sel_req.cmd == muoa_pkg::CMD_SERVICE_OP &&
        (mode_reg != muoa_pkg::MODE_SERVICE || owner_reg != sel_uid)) |=>
        !rsp_reg[$past(sel_uid)].granted)
        else $error("service operation granted to non owner");
    a_owner_stable: assert property (
        (owner_vld_reg && $past(owner_vld_reg)) |-> $stable(owner_reg))
        else $error("state owner changed while held");
    a_idle_no_owner: assert property (
        mode_reg == muoa_pkg::MODE_IDLE |-> !owner_vld_reg)
        else $error("owner kept in idle mode");

endmodule

// ===== sim/muoa_link_partner.sv
/*
 * Wireless link module model on the far side of each user channel.
 * Assumes the arbiter's clock; echoes what it receives one cycle later.
 */
`timescale 1ns/100ps
module muoa_link_partner (
    input wire logic clk_in,
    input wire logic [2:0] rx_in,
    output logic [2:0] tx_out
);
    // ****************************************
    // Loopback of receive to transmit
    // ****************************************
    initial tx_out = 3'h7;
    always @(posedge clk_in) begin
        tx_out <= rx_in;
    end
endmodule

// ===== sim/muoa_arbiter_test.sv
/*
 * Self-checking bench for the multi user owner arbiter.
 * Assumes the link partner model and a 10 MHz clock.
 */
`timescale 1ns/100ps
module muoa_arbiter_test;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    muoa_pkg::muoa_req_s [2:0] req_in = '0;
    muoa_pkg::muoa_rsp_s [2:0] rsp_out;
    logic overload_in = 1'b0;
    logic ack_sample_in = 1'b0;
    logic small_board_in = 1'b0;
    logic [2:0] link_tx_in = 3'h7;
    logic [2:0] tx_pin, rx_pin, link_rx_out;
    logic led_out, bridge_en_out;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    int fails = 0;
    int samples_checked = 0;

    always #50 clk_in = ~clk_in;

    muoa_arbiter #(.CYC_PER_MS(4), .NUM_USERS(3)) i_muoa_arbiter (
        .clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in),
        .rsp_out(rsp_out), .overload_in(overload_in),
        .ack_sample_in(ack_sample_in), .small_board_in(small_board_in),
        .link_tx_in(link_tx_in), .link_tx_pin_out(tx_pin),
        .link_rx_pin_in(rx_pin), .link_rx_out(link_rx_out),
        .led_out(led_out), .bridge_en_out(bridge_en_out),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out));

    muoa_link_partner i_muoa_link_partner (
        .clk_in(clk_in), .rx_in(tx_pin), .tx_out(rx_pin));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic stop_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 check("rdata", reg_rdata_out, e);
    endtask

    task automatic req(input int u, input muoa_pkg::muoa_cmd_e c,
                       input logic [13:0] a, input logic [1:0] e);
        int k;
        k = 0;
        @(posedge clk_in);
        req_in[u] <= {1'b1, c, a};
        do begin
            @(posedge clk_in);
            k++;
        end while (rsp_out[u].done !== 1'b1 && k < 20);
        req_in[u].valid <= 1'b0;
        check("done", 32'(rsp_out[u].done), 32'h1);
        check("grant_lock", 32'({rsp_out[u].granted, rsp_out[u].locked}),
              32'(e));
        @(posedge clk_in);
    endtask

    task automatic rises(input int n, input int e);
        int r;
        logic last;
        r = 0;
        @(posedge clk_in);
        #1 last = led_out;
        repeat (n) begin
            @(posedge clk_in);
            #1 if (led_out === 1'b1 && last !== 1'b1) r++;
            last = led_out;
        end
        check("led_rises", r, e);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd(8'h00, 32'h3);
        rd(8'h08, 32'h6);
        rd(8'h0C, 32'h0);
        req(0, muoa_pkg::CMD_NONE, 14'h0, 2'b00);
        rises(16000, 2);
        req(1, muoa_pkg::CMD_GO_OPER, 14'h0, 2'b10);
        req(2, muoa_pkg::CMD_GO_SERVICE, 14'h0, 2'b00);
        rd(8'h04, 32'h46);
        req(0, muoa_pkg::CMD_SEL_ENGINE, 14'h5, 2'b10);
        req(0, muoa_pkg::CMD_ENGINE, 14'h5, 2'b10);
        req(1, muoa_pkg::CMD_SEL_ENGINE, 14'h5, 2'b10);
        req(1, muoa_pkg::CMD_ENGINE, 14'h5, 2'b01);
        wr(8'h00, 32'h2);
        req(1, muoa_pkg::CMD_ENGINE, 14'h5, 2'b10);
        req(0, muoa_pkg::CMD_ACCESSORY, 14'h9, 2'b10);
        req(2, muoa_pkg::CMD_ACCESSORY, 14'h9, 2'b01);
        wr(8'h00, 32'h3);
        req(1, muoa_pkg::CMD_GO_SERVICE, 14'h0, 2'b10);
        req(2, muoa_pkg::CMD_SERVICE_OP, 14'h0, 2'b00);
        req(1, muoa_pkg::CMD_SERVICE_OP, 14'h0, 2'b10);
        ack_sample_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("led_ack", led_out, 1'b1);
        ack_sample_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("led_dark", led_out, 1'b0);
        req(1, muoa_pkg::CMD_GO_IDLE, 14'h0, 2'b10);
        req(2, muoa_pkg::CMD_GO_OPER, 14'h0, 2'b10);
        req(2, muoa_pkg::CMD_SEL_ENGINE, 14'h5, 2'b10);
        req(2, muoa_pkg::CMD_ENGINE, 14'h5, 2'b10);
        link_tx_in <= 3'h2;
        repeat (6) @(posedge clk_in);
        check("link_rx", link_rx_out, 3'h2);
        overload_in <= 1'b1;
        @(posedge clk_in);
        overload_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("bridge_off", bridge_en_out, 1'b0);
        rises(4000, 4);
        wr(8'h00, 32'h7);
        repeat (3) @(posedge clk_in);
        check("bridge_on", bridge_en_out, 1'b1);
        nrst_in <= 1'b0;
        small_board_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(8'h08, 32'h7);
        stop_test();
    end

    initial begin
        #4_000_000;
        fails++;
        stop_test();
    end
endmodule
